/* hdl/adcsp_serial_port.sv */
// Purpose: Serial port of a 12-bit converter, five interface modes
// Assumes: Link logic runs on the master clock, host pins slower than it
// Notes: Generated serial clock runs at a quarter of the master clock
`timescale 1ns/100ps
`default_nettype none
module adcsp_serial_port (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_MASTER_CLOCK_IN,
  input wire logic I_MODE_SELECT_HI,
  input wire logic I_MODE_SELECT_LO,
  input wire logic I_EDGE_SELECT,
  input wire logic I_TWO_WIRE_EN,
  input wire logic I_START,
  input wire logic I_TX_LOAD,
  input wire logic [15:0] I_TX_WORD,
  input wire logic I_SCLK_IN,
  input wire logic I_FSYNC_N_IN,
  input wire logic I_DIN_IN,
  output logic O_SCLK_OUT,
  output logic O_SCLK_OE,
  output logic O_FSYNC_N_OUT,
  output logic O_FSYNC_OE,
  output logic O_DOUT,
  output logic O_DOUT_OE,
  output logic O_DIN_OUT,
  output logic O_DIN_OE,
  output logic [15:0] O_RX_WORD,
  output logic O_RX_VALID,
  output logic [2:0] O_MODE
);

  function automatic adcsp_pkg::adcsp_mode_t mode_of(input logic hi, input logic lo,
                                                    input logic two_wire);
    adcsp_pkg::adcsp_mode_t m;
    m = adcsp_pkg::MODE_2;
    if ({hi, lo} == adcsp_pkg::SEL_M3) begin
      m = adcsp_pkg::MODE_3;
    end else if ({hi, lo} == adcsp_pkg::SEL_M4) begin
      m = adcsp_pkg::MODE_4;
    end else if ({hi, lo} == adcsp_pkg::SEL_M5) begin
      m = adcsp_pkg::MODE_5;
    end else if (two_wire) begin
      m = adcsp_pkg::MODE_1;
    end
    return m;
  endfunction

  function automatic logic is_ext(input adcsp_pkg::adcsp_mode_t m);
    return (m == adcsp_pkg::MODE_1) || (m == adcsp_pkg::MODE_2) ||
           (m == adcsp_pkg::MODE_3);
  endfunction

  // User side state, I_CLK domain
  typedef struct packed {
    logic [15:0] tx_hold;
    logic tx_tgl;
    logic start_tgl;
    logic two_wire;
    logic rx_seen;
    logic [15:0] rx_word;
    logic rx_valid;
  } adcsp_user_t;

  // Link side state, master clock domain
  typedef struct packed {
    adcsp_pkg::adcsp_mode_t mode;
    logic sclk_prev;
    logic fsync_prev;
    logic active;
    logic opened;
    logic msb_shown;
    logic phase_read;
    logic [4:0] cnt;
    logic [4:0] cnt_tx;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [15:0] rx_hold;
    logic rx_tgl;
    logic [15:0] tx_word;
    logic tx_seen;
    logic start_seen;
    logic start_pend;
    logic [1:0] gen_div;
    logic [1:0] samp_dly;
    logic sclk_o;
    logic fsync_o;
    logic gen_oe;
    logic dout;
    logic dout_oe;
    logic din_o;
    logic din_oe;
  } adcsp_link_t;

  adcsp_user_t u_q;
  adcsp_user_t u_d;
  adcsp_link_t k_q;
  adcsp_link_t k_d;

  logic s_sclk, s_fsync_n, s_din, s_hi, s_lo, s_edge, s_two_wire, s_tx_tgl, s_start_tgl;
  logic s_rx_tgl;
  logic ext, rise, fall, out_edge, samp_edge, fs_fall, word_done, gen_tick;
  logic [15:0] rx_next;

  adcsp_sync #(
    .WIDTH(9),
    .RST_VAL(9'h080)
  ) u_sync_link (
    .i_clk(I_MASTER_CLOCK_IN),
    .i_arst_n(I_ARST_N),
    .i_d({I_SCLK_IN, I_FSYNC_N_IN, I_DIN_IN, I_MODE_SELECT_HI, I_MODE_SELECT_LO,
          I_EDGE_SELECT, u_q.two_wire, u_q.tx_tgl, u_q.start_tgl}),
    .o_q({s_sclk, s_fsync_n, s_din, s_hi, s_lo, s_edge, s_two_wire, s_tx_tgl,
          s_start_tgl})
  );

  adcsp_sync #(
    .WIDTH(1),
    .RST_VAL(1'h0)
  ) u_sync_user (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_d(k_q.rx_tgl),
    .o_q(s_rx_tgl)
  );

  // User side: words pass by toggle, data held stable meanwhile
  always_comb begin
    u_d = u_q;
    u_d.two_wire = I_TWO_WIRE_EN;
    u_d.rx_valid = 1'b0;
    u_d.rx_seen = s_rx_tgl;
    if (I_TX_LOAD) begin
      u_d.tx_hold = I_TX_WORD;
      u_d.tx_tgl = ~u_q.tx_tgl;
    end
    if (I_START) begin
      u_d.start_tgl = ~u_q.start_tgl;
    end
    if (s_rx_tgl != u_q.rx_seen) begin
      u_d.rx_word = k_q.rx_hold;
      u_d.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      u_q <= '0;
    end else begin
      u_q <= u_d;
    end
  end

  always_comb begin
    ext = is_ext(k_q.mode);
    rise = s_sclk & ~k_q.sclk_prev;
    fall = ~s_sclk & k_q.sclk_prev;
    out_edge = s_edge ? fall : rise;
    samp_edge = s_edge ? rise : fall;
    fs_fall = ~s_fsync_n & k_q.fsync_prev;
    gen_tick = (k_q.gen_div == adcsp_pkg::GEN_DIV_LAST);
    rx_next = {k_q.rx_shift[14:0], s_din};
    word_done = ext ? (k_q.active & ~s_fsync_n & ~fs_fall & samp_edge &
                       (k_q.cnt == adcsp_pkg::WORD_LAST))
                    : (k_q.samp_dly[1] & (k_q.cnt == adcsp_pkg::WORD_LAST));
  end

  always_comb begin
    k_d = k_q;
    k_d.mode = mode_of(s_hi, s_lo, s_two_wire);
    k_d.sclk_prev = s_sclk;
    k_d.fsync_prev = s_fsync_n;
    k_d.tx_seen = s_tx_tgl;
    k_d.start_seen = s_start_tgl;
    k_d.samp_dly = {k_q.samp_dly[0], 1'b0};
    k_d.gen_div = gen_tick ? adcsp_pkg::GEN_DIV_RESET : k_q.gen_div + 2'h1;
    if (s_tx_tgl != k_q.tx_seen) begin
      k_d.tx_word = u_q.tx_hold;
    end
    if (s_start_tgl != k_q.start_seen) begin
      k_d.start_pend = 1'b1;
    end
    if (ext) begin
      k_d.sclk_o = s_edge;
      k_d.fsync_o = 1'b1;
      k_d.start_pend = 1'b0;
      if (s_fsync_n) begin
        k_d.active = 1'b0;
        k_d.opened = 1'b0;
        k_d.cnt = adcsp_pkg::CNT_RESET;
        k_d.rx_shift = adcsp_pkg::WORD_RESET;
      end else if (fs_fall) begin
        k_d.active = 1'b1;
        k_d.opened = 1'b1;
        k_d.cnt = adcsp_pkg::CNT_RESET;
        k_d.tx_shift = k_q.tx_word;
        k_d.msb_shown = s_edge ? ~s_sclk : s_sclk;
      end else if (k_q.active) begin
        if (out_edge) begin
          if (!k_q.msb_shown) begin
            k_d.msb_shown = 1'b1;
          end else begin
            k_d.tx_shift = {k_q.tx_shift[14:0], 1'b0};
          end
        end
        if (samp_edge) begin
          k_d.rx_shift = rx_next;
          k_d.cnt = k_q.cnt + 5'h01;
        end
        if (word_done) begin
          k_d.cnt = adcsp_pkg::CNT_RESET;
          k_d.msb_shown = 1'b0;
          k_d.tx_shift = k_q.tx_word;
          if (!(k_q.mode == adcsp_pkg::MODE_1 && k_q.phase_read)) begin
            k_d.rx_hold = rx_next;
            k_d.rx_tgl = ~k_q.rx_tgl;
          end
          if (k_q.mode == adcsp_pkg::MODE_1) begin
            k_d.phase_read = ~k_q.phase_read;
          end
          if (k_q.mode == adcsp_pkg::MODE_3) begin
            k_d.active = 1'b0;
          end
        end
      end
    end else begin
      k_d.opened = 1'b0;
      k_d.phase_read = 1'b0;
      if (gen_tick) begin
        if (k_q.active) begin
          k_d.sclk_o = ~k_q.sclk_o;
          if (k_q.sclk_o == s_edge) begin
            k_d.samp_dly[0] = 1'b1;
            k_d.cnt_tx = k_q.cnt_tx + 5'h01;
          end else if (k_q.cnt_tx == adcsp_pkg::WORD_DONE) begin
            k_d.active = 1'b0;
            k_d.fsync_o = 1'b1;
          end else begin
            k_d.tx_shift = {k_q.tx_shift[14:0], 1'b0};
          end
        end else if (k_q.start_pend &&
                     (k_q.mode == adcsp_pkg::MODE_4 || k_q.sclk_o != s_edge)) begin
          k_d.active = 1'b1;
          k_d.start_pend = 1'b0;
          k_d.fsync_o = 1'b0;
          k_d.tx_shift = k_q.tx_word;
          k_d.cnt_tx = adcsp_pkg::CNT_RESET;
          k_d.cnt = adcsp_pkg::CNT_RESET;
          k_d.sclk_o = s_edge;
        end else if (k_q.mode == adcsp_pkg::MODE_5) begin
          k_d.sclk_o = ~k_q.sclk_o;
        end else begin
          k_d.sclk_o = s_edge;
        end
      end
      if (k_q.samp_dly[1]) begin
        k_d.rx_shift = rx_next;
        k_d.cnt = k_q.cnt + 5'h01;
        if (word_done) begin
          k_d.cnt = adcsp_pkg::CNT_RESET;
          k_d.rx_hold = rx_next;
          k_d.rx_tgl = ~k_q.rx_tgl;
        end
      end
    end
    k_d.gen_oe = ~is_ext(k_d.mode);
    k_d.dout = k_d.tx_shift[15];
    k_d.din_o = k_d.tx_shift[15];
    k_d.dout_oe = is_ext(k_d.mode) ? (k_d.opened & (k_d.mode != adcsp_pkg::MODE_1))
                                   : k_d.active;
    k_d.din_oe = (k_d.mode == adcsp_pkg::MODE_1) & k_d.opened & k_d.phase_read;
  end

  always_ff @(posedge I_MASTER_CLOCK_IN or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      k_q <= '0;
      k_q.mode <= adcsp_pkg::MODE_2;
      k_q.fsync_prev <= 1'b1;
      k_q.fsync_o <= 1'b1;
    end else begin
      k_q <= k_d;
    end
  end

  assign O_SCLK_OUT = k_q.sclk_o;
  assign O_SCLK_OE = k_q.gen_oe;
  assign O_FSYNC_N_OUT = k_q.fsync_o;
  assign O_FSYNC_OE = k_q.gen_oe;
  assign O_DOUT = k_q.dout;
  assign O_DOUT_OE = k_q.dout_oe;
  assign O_DIN_OUT = k_q.din_o;
  assign O_DIN_OE = k_q.din_oe;
  assign O_RX_WORD = u_q.rx_word;
  assign O_RX_VALID = u_q.rx_valid;
  assign O_MODE = k_q.mode;

  a_mode_pins: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    {s_hi, s_lo} == adcsp_pkg::SEL_M3 |=> k_q.mode == adcsp_pkg::MODE_3)
    else $error("Mode pins 01 did not select mode 3");

  a_mode_default: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    !s_hi && !s_lo && !s_two_wire |=> k_q.mode == adcsp_pkg::MODE_2)
    else $error("Default mode is not mode 2");

  a_mode_two_wire: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    $rose(k_q.mode == adcsp_pkg::MODE_1) |-> $past(s_two_wire) && !$past(s_hi))
    else $error("Mode 1 entered without two-wire setting");

  a_sync_clear: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    ext && s_fsync_n |=> k_q.cnt == adcsp_pkg::CNT_RESET && !k_q.active &&
                         k_q.rx_shift == adcsp_pkg::WORD_RESET)
    else $error("Frame sync high did not clear the shift register");

  a_msb_on_fall: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    ext && fs_fall && (s_edge != s_sclk) |=> k_q.msb_shown &&
                                              k_q.dout == $past(k_q.tx_word[15]))
    else $error("Sync fall did not present the top bit");

  a_out_shift: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    ext && k_q.active && !s_fsync_n && !fs_fall && out_edge && k_q.msb_shown
    |=> k_q.tx_shift == {$past(k_q.tx_shift[14:0]), 1'b0})
    else $error("Output edge did not advance the word");

  a_m3_count: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_3 && word_done |=> !k_q.active ##1 !k_q.active)
    else $error("Mode 3 frame did not end after 16 clocks");

  a_m1_turn: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_1 && word_done && !k_q.phase_read && s_two_wire
    |=> k_q.phase_read && k_q.din_oe)
    else $error("Mode 1 data pin did not turn to output");

  a_gen_frame: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_4 && $fell(k_q.fsync_o) && $stable(k_q.mode)
    |-> ##63 !k_q.fsync_o ##1 k_q.fsync_o)
    else $error("Mode 4 frame is not 16 clocks long");

  a_gen_first: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    !ext && $fell(k_q.fsync_o) |-> k_q.dout == $past(k_q.tx_word[15]) && k_q.dout_oe)
    else $error("Own frame sync did not present the first bit");

  a_m5_free: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_5 && $past(k_q.mode) == adcsp_pkg::MODE_5
    |-> ##[1:2] $changed(k_q.sclk_o))
    else $error("Mode 5 clock is not running");

  a_ext_tristate: assert property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    ext && s_fsync_n && is_ext(k_d.mode) |=> !k_q.dout_oe && !k_q.din_oe && !k_q.gen_oe)
    else $error("Data output driven outside the frame");

  c_m1_read: cover property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_1 && $rose(k_q.din_oe));
  c_m3_word: cover property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_3 && word_done);
  c_m4_frame: cover property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_4 && $rose(k_q.fsync_o));
  c_m5_frame: cover property (@(posedge I_MASTER_CLOCK_IN) disable iff (!I_ARST_N)
    k_q.mode == adcsp_pkg::MODE_5 && $fell(k_q.fsync_o));
  c_rx_valid: cover property (@(posedge I_CLK) disable iff (!I_ARST_N) u_q.rx_valid);

endmodule
`default_nettype wire

/* pkg/adcsp_pkg.sv */
// Purpose: Shared constants and types of the converter serial port
// Assumes: 16-bit words shifted most significant bit first
// Notes: Mode pin codes and counts are named once here
package adcsp_pkg;

  // Interface modes 1 to 5
  typedef enum logic [2:0] {
    MODE_1,
    MODE_2,
    MODE_3,
    MODE_4,
    MODE_5
  } adcsp_mode_t;

  // Codes on the two mode select pins, high pin first
  localparam logic [1:0] SEL_M12 = 2'h0;
  localparam logic [1:0] SEL_M3 = 2'h1;
  localparam logic [1:0] SEL_M4 = 2'h2;
  localparam logic [1:0] SEL_M5 = 2'h3;

  localparam int WORD_BITS = 16;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [4:0] WORD_LAST = 5'h0F;
  localparam logic [4:0] WORD_DONE = 5'h10;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Generated serial clock half period, in master clocks, minus one
  localparam logic [1:0] GEN_DIV_LAST = 2'h1;
  localparam logic [1:0] GEN_DIV_RESET = 2'h0;

  // Word the host writes after an interface reset
  localparam logic [15:0] TEST_RESTORE_WORD = 16'h4002;

endpackage

/* hdl/adcsp_sync.sv */
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Each bit is an independent level
// Notes: Reset value is per bit so idle-high pins start high
`timescale 1ns/100ps
`default_nettype none
module adcsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adcsp_sync_st_t;

  adcsp_sync_st_t s_q;
  adcsp_sync_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = i_d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_q = s_q.stable;

endmodule
`default_nettype wire

/* verification/adcsp_host_model.sv */
// Purpose: Host serial port and frame slave facing the converter port
// Assumes: Host clock half period far above four master clocks
// Notes: A released data line shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module adcsp_host_model (
  input wire logic i_edge_sel,
  input wire logic i_dev_sclk,
  input wire logic i_dev_fsync_n,
  input wire logic i_dev_dout,
  input wire logic i_dev_din_out,
  input wire logic i_dev_din_oe,
  output logic o_sclk,
  output logic o_fsync_n,
  output logic o_din
);
  localparam int HP = 400;
  logic host_din = 1'h0;
  logic [15:0] s_tx = 16'h0000;
  logic [15:0] s_rx = 16'h0000;
  int s_cnt = 0;
  initial begin
    o_sclk = 1'h1;
    o_fsync_n = 1'h1;
  end
  assign o_din = (i_dev_din_oe === 1'h1) ? i_dev_din_out : host_din;
  task automatic set_idle(input logic es);
    o_sclk = ~es;
  endtask
  task automatic sync_high();
    o_fsync_n = 1'h1;
    host_din = ~host_din;
    #HP;
  endtask
  // Sync fall, n sample edges, then extra clock pulses
  task automatic frame(input logic [15:0] w, input int n, input int extra, input bit keep_low,
      input bit from_pin, output logic [15:0] got);
    got = 16'h0000;
    host_din = w[15];
    o_fsync_n = 1'h0;
    #HP;
    for (int i = 0; i < n + extra; i++) begin
      o_sclk = ~o_sclk;
      if (i < n) got = {got[14:0], from_pin ? o_din : i_dev_dout};
      #HP;
      o_sclk = ~o_sclk;
      host_din = (i < 15) ? w[14 - i] : ~host_din;
      #HP;
    end
    if (!keep_low) sync_high();
  endtask
  // Slave side of a device generated frame
  always @(negedge i_dev_fsync_n) begin
    s_cnt = 0;
    host_din = s_tx[15];
  end
  always @(i_dev_sclk) begin
    if (i_dev_fsync_n === 1'h0 && (i_dev_sclk ^ i_edge_sel) === 1'h1) begin
      s_rx = {s_rx[14:0], i_dev_dout};
      s_cnt++;
    end else if (i_dev_fsync_n === 1'h0 && s_cnt < 16 && s_cnt > 0) begin
      host_din = s_tx[15 - s_cnt];
    end
  end
endmodule
`default_nettype wire

/* verification/test_adcsp_serial_port.sv */
// Purpose: Self-checking bench of the converter serial port
// Assumes: Host and slave behaviour come from the partner model
// Notes: Link clock 48 ns, user clock 25 ns, unrelated phases
`timescale 1ns/100ps
`default_nettype none
module test_adcsp_serial_port;
  logic clk = 1'h0;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic sel_hi = 1'h0, sel_lo = 1'h0, edge_sel = 1'h0, two_wire = 1'h0;
  logic start = 1'h0, tx_load = 1'h0;
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word, rx_last = 16'h0000, got;
  logic sclk_h, fsync_h, din_w, sclk_o, sclk_oe, fs_o, fs_oe, dout, dout_oe;
  logic dinp_o, dinp_oe, rx_valid;
  logic [2:0] mode;
  wire logic sclk_w, fsync_w;
  int err_total = 0, n_checks = 0, rx_n = 0, idle_n = 0, cyc = 0;
  // The shared pins follow whichever party drives them
  assign sclk_w = (sclk_oe === 1'h1) ? sclk_o : sclk_h;
  assign fsync_w = (fs_oe === 1'h1) ? fs_o : fsync_h;
  adcsp_serial_port i_adcsp_serial_port (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_MASTER_CLOCK_IN(mclk),
    .I_MODE_SELECT_HI(sel_hi), .I_MODE_SELECT_LO(sel_lo), .I_EDGE_SELECT(edge_sel),
    .I_TWO_WIRE_EN(two_wire), .I_START(start), .I_TX_LOAD(tx_load), .I_TX_WORD(tx_word),
    .I_SCLK_IN(sclk_w), .I_FSYNC_N_IN(fsync_w), .I_DIN_IN(din_w),
    .O_SCLK_OUT(sclk_o), .O_SCLK_OE(sclk_oe), .O_FSYNC_N_OUT(fs_o), .O_FSYNC_OE(fs_oe),
    .O_DOUT(dout), .O_DOUT_OE(dout_oe), .O_DIN_OUT(dinp_o), .O_DIN_OE(dinp_oe),
    .O_RX_WORD(rx_word), .O_RX_VALID(rx_valid), .O_MODE(mode)
  );
  adcsp_host_model i_adcsp_host_model (
    .i_edge_sel(edge_sel), .i_dev_sclk(sclk_o), .i_dev_fsync_n(fs_o | ~fs_oe),
    .i_dev_dout(dout), .i_dev_din_out(dinp_o), .i_dev_din_oe(dinp_oe),
    .o_sclk(sclk_h), .o_fsync_n(fsync_h), .o_din(din_w)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    #7;
    forever #24 mclk = ~mclk;
  end
  // Sample the user outputs mid-cycle, where they have settled
  always @(negedge clk) begin
    cyc++;
    if (rx_valid === 1'h1) begin
      rx_n++;
      rx_last = rx_word;
    end
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  always @(posedge sclk_o) begin
    if (fs_o === 1'h1) idle_n++;
  end
  task automatic report_and_stop();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_mode(input string nm, input logic [2:0] e, input logic [2:0] s);
    chk_word(nm, {13'h0000, e}, {13'h0000, s});
  endtask
  task automatic chk_count(input string nm, input int e, input int s);
    n_checks++;
    if (s != e) begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic set_pins(input logic hi, input logic lo, input logic es, input logic tw);
    @(posedge clk);
    sel_hi <= hi;
    sel_lo <= lo;
    edge_sel <= es;
    two_wire <= tw;
    repeat (20) @(posedge clk);
    i_adcsp_host_model.set_idle(es);
  endtask
  task automatic load(input logic [15:0] w);
    @(posedge clk);
    tx_word <= w;
    tx_load <= 1'h1;
    @(posedge clk);
    tx_load <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_modes();
    set_pins(1'h0, 1'h0, 1'h0, 1'h0);
    chk_mode("mode pins 00", adcsp_pkg::MODE_2, mode);
    set_pins(1'h0, 1'h0, 1'h0, 1'h1);
    chk_mode("mode two wire", adcsp_pkg::MODE_1, mode);
    set_pins(1'h0, 1'h1, 1'h0, 1'h0);
    chk_mode("mode pins 01", adcsp_pkg::MODE_3, mode);
    set_pins(1'h1, 1'h0, 1'h0, 1'h1);
    chk_mode("mode pins 10", adcsp_pkg::MODE_4, mode);
    set_pins(1'h1, 1'h1, 1'h0, 1'h0);
    chk_mode("mode pins 11", adcsp_pkg::MODE_5, mode);
  endtask
  task automatic t_host(input logic es, input logic [15:0] w);
    int n0;
    set_pins(1'h0, 1'h0, es, 1'h0);
    load(w);
    n0 = rx_n;
    i_adcsp_host_model.frame(~w, 16, 0, 1'h0, 1'h0, got);
    repeat (8) @(posedge clk);
    chk_word("dout word", w, got);
    chk_word("rx word", ~w, rx_last);
    chk_count("rx pulses", n0 + 1, rx_n);
    chk_word("dout oe idle", 16'h0000, {15'h0000, dout_oe});
  endtask
  task automatic t_sync_reset();
    int n0;
    set_pins(1'h0, 1'h0, 1'h0, 1'h0);
    n0 = rx_n;
    i_adcsp_host_model.frame(16'hFFFF, 5, 0, 1'h0, 1'h0, got);
    i_adcsp_host_model.frame(adcsp_pkg::TEST_RESTORE_WORD, 16, 0, 1'h0, 1'h0, got);
    repeat (8) @(posedge clk);
    chk_word("rx after sync reset", adcsp_pkg::TEST_RESTORE_WORD, rx_last);
    chk_count("rx pulses after reset", n0 + 1, rx_n);
  endtask
  task automatic t_mode3();
    int n0;
    set_pins(1'h0, 1'h1, 1'h1, 1'h0);
    load(16'h3C5A);
    n0 = rx_n;
    i_adcsp_host_model.frame(16'hA5C3, 16, 4, 1'h1, 1'h0, got);
    repeat (8) @(posedge clk);
    chk_word("mode 3 dout", 16'h3C5A, got);
    chk_word("mode 3 rx", 16'hA5C3, rx_last);
    chk_count("mode 3 pulses", n0 + 1, rx_n);
    i_adcsp_host_model.sync_high();
  endtask
  task automatic t_two_wire();
    set_pins(1'h0, 1'h0, 1'h0, 1'h1);
    load(16'h1234);
    i_adcsp_host_model.frame(16'hC0DE, 16, 0, 1'h1, 1'h0, got);
    repeat (8) @(posedge clk);
    chk_word("din oe after write", 16'h0001, {15'h0000, dinp_oe});
    chk_word("write word", 16'hC0DE, rx_last);
    i_adcsp_host_model.sync_high();
    load(16'h1234);
    i_adcsp_host_model.frame(16'h0000, 16, 0, 1'h0, 1'h1, got);
    chk_word("read word", 16'h1234, got);
    chk_word("din oe released", 16'h0000, {15'h0000, dinp_oe});
  endtask
  task automatic t_gen(input logic lo, input logic es, input logic [15:0] w, input logic [15:0] s);
    int n0;
    int k;
    set_pins(1'h1, lo, es, 1'h0);
    load(w);
    i_adcsp_host_model.s_tx = s;
    n0 = rx_n;
    k = 0;
    @(posedge clk);
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    while (fs_o !== 1'h0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    while (fs_o !== 1'h1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
    idle_n = 0;
    repeat (40) @(posedge clk);
    chk_word("gen dout word", w, i_adcsp_host_model.s_rx);
    chk_count("gen pulses", 16, i_adcsp_host_model.s_cnt);
    chk_word("gen rx word", s, rx_last);
    chk_count("gen rx pulses", n0 + 1, rx_n);
    chk_count("free clock", int'(lo), int'(idle_n > 0));
  endtask
  initial begin
    repeat (12) @(posedge clk);
    chk_mode("mode in reset", adcsp_pkg::MODE_2, mode);
    arst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_modes();
    t_host(1'h0, 16'h8C31);
    t_host(1'h1, 16'h5AF0);
    t_sync_reset();
    t_mode3();
    t_two_wire();
    t_gen(1'h0, 1'h0, 16'hB00C, 16'h6E19);
    t_gen(1'h1, 1'h1, 16'h4AD2, 16'h93E5);
    t_gen(1'h0, 1'h1, 16'h0F81, 16'hF00F);
    report_and_stop();
  end
endmodule
`default_nettype wire
